// >>> rtl/pfs_pkg.sv
// Package for the fault status bank: register codes, bit positions,
// reset values, clear timing and the page and shared event carrier structs.
// Assumes a command decoder that hands this bank decoded accesses.
package pfs_pkg;

  // Register selectors (command codes seen on the serial interface)
  localparam logic [7:0] CMD_SUMMARY_BYTE = 8'h78;
  localparam logic [7:0] CMD_SUMMARY_WORD = 8'h79;
  localparam logic [7:0] CMD_VOUT_FLAGS   = 8'h7A;
  localparam logic [7:0] CMD_IOUT_FLAGS   = 8'h7B;
  localparam logic [7:0] CMD_INPUT_FLAGS  = 8'h7C;
  localparam logic [7:0] CMD_TEMP_FLAGS   = 8'h7D;
  localparam logic [7:0] CMD_CML_FLAGS    = 8'h7E;
  localparam logic [7:0] CMD_MFR_FLAGS    = 8'h80;

  // Supported-bit, write-one-clear, alert and shared masks; bits outside the supported masks read zero
  localparam logic [7:0] VOUT_MASK  = 8'hFE;
  localparam logic [7:0] IOUT_MASK  = 8'hA0;
  localparam logic [7:0] INPUT_MASK = 8'hAA;
  localparam logic [7:0] INPUT_W1C  = 8'h80;
  localparam logic [7:0] INPUT_ALRT = 8'h80;
  localparam logic [7:0] TEMP_MASK  = 8'hD0;
  localparam logic [7:0] CML_MASK   = 8'hFB;
  localparam logic [7:0] MFR_MASK   = 8'hFD;
  localparam logic [7:0] MFR_SHARED = 8'hFC;
  localparam logic [7:0] MFR_W1C    = 8'hF7;
  localparam int         MFR_LOG_BIT = 3;
  localparam int         MFR_GPIO_BIT = 0;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // Summary byte bit positions
  localparam int SB_BUSY = 7;
  localparam int SB_OFF  = 6;
  localparam int SB_OV   = 5;
  localparam int SB_OC   = 4;
  localparam int SB_UV   = 3;
  localparam int SB_TEMP = 2;
  localparam int SB_CML  = 1;
  localparam int SB_NOTA = 0;
  // Summary word high-byte positions (within high byte)
  localparam int SW_VOUT = 7;
  localparam int SW_IOUT = 6;
  localparam int SW_IN   = 5;
  localparam int SW_MFR  = 4;
  localparam int SW_PGN  = 3;

  localparam int OUTPUT_OVERVOLTAGE_SUMMARY_FAULT_BIT = 7;
  localparam int OUTPUT_OVERCURRENT_SUMMARY_FAULT_BIT = 7;

  // Global clear processing time
  localparam int CLR_TIME_NS  = 10000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int CLR_CYCLES   = CLR_TIME_NS / CLK_PERIOD_NS;
  localparam int CLR_CNT_W    = 11;

  localparam int NPAGE = 2;

  // Per-page fault events from the detectors, one-cycle pulses
  typedef struct packed {
    logic [7:0] vout;
    logic [7:0] iout;
    logic [7:0] temp;
    logic       gpio_low;
    logic       other;
  } pfs_page_evt_s;

  // Shared fault events
  typedef struct packed {
    logic [7:0] input_flags;
    logic [7:0] comm_memory_logic_summary;
    logic [7:0] mfr;
    logic       busy;
    logic       other;
  } pfs_shared_evt_s;

  typedef enum logic [1:0] {
    CLR_IDLE = 2'b01,
    CLR_BUSY = 2'b10
  } pfs_clr_e;

endpackage : pfs_pkg

// >>> rtl/pfs_status_bank.sv
// Fault and warning status bank for a two-page power controller.
// Assumes a command decoder on core_clk giving one-cycle access strobes
// and fault detectors giving one-cycle event pulses on core_clk.
//
// How it works
// - Busy summary bit sets when a response timeout fault is declared.
// - Off summary bit follows selected channel not delivering power.
// - Unsupported status bits always read as zero.
// - None-of-the-above sets only on a page or shared other-fault event.
// - Any supported summary bit except off, or any maker bit, set raises ALERT.
// - Summary word low byte mirrors the summary byte.
// - Word high byte flags vout, iout, input, maker, power-not-good.
// - Output-voltage byte holds seven fault and warning bits, bits 7..1.
// - Writing ones clears only those output-voltage bits.
// - Current byte: fault bit 7, warning bit 5, write-one clears.
// - Input byte: bits 7, 5, 3, 1 supported, rest zero.
// - Only input bit 7 alerts and clears by writing one.
// - Temperature byte: bits 7, 6, 4; alert and write-one clear.
// - Comm/memory/logic byte: seven flags, bit 2 reserved zero.
// - Comm/memory/logic bits alert and clear individually by write-one.
// - Maker byte: internal temp, crc, pll, log, 3v3 supply, gpio.
// - Maker byte shared across pages except per-page bit 0.
// - Any maker bit set sets the maker flag in word high byte.
// - Maker bits clear by write-one except log bit, cleared by erase.
// - Temperature summary sets on any temperature fault or warning.
// - Comm/memory/logic summary sets when any such fault recorded.
// - Global clear wipes all flags, releases ALERT, events still re-set.
`timescale 1ns/1ps
module pfs_status_bank (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  // Register access from the command decoder
  input  wire logic                      page_sel,
  input  wire logic [7:0]                reg_sel,
  input  wire logic                      wr_stb,
  input  wire logic [7:0]                wr_data,
  input  wire logic                      clear_all_cmd,
  input  wire logic                      fault_log_erase_cmd,
  output logic      [15:0]               rd_data,
  output logic                           clear_busy,
  // Fault events and channel state
  input  wire pfs_pkg::pfs_page_evt_s    page_evt [pfs_pkg::NPAGE],
  input  wire pfs_pkg::pfs_shared_evt_s  shared_evt,
  input  wire logic [pfs_pkg::NPAGE-1:0] chan_off,
  input  wire logic [pfs_pkg::NPAGE-1:0] power_not_good,
  // Alert toward the host
  output logic                           alert
);

  logic [7:0] vout_r [pfs_pkg::NPAGE];
  logic [7:0] vout_nxt [pfs_pkg::NPAGE];
  logic [7:0] iout_r [pfs_pkg::NPAGE];
  logic [7:0] iout_nxt [pfs_pkg::NPAGE];
  logic [7:0] temp_r [pfs_pkg::NPAGE];
  logic [7:0] temp_nxt [pfs_pkg::NPAGE];
  logic       gpio_r [pfs_pkg::NPAGE];
  logic       gpio_nxt [pfs_pkg::NPAGE];
  logic       busy_r [pfs_pkg::NPAGE];
  logic       busy_nxt [pfs_pkg::NPAGE];
  logic       nota_r [pfs_pkg::NPAGE];
  logic       nota_nxt [pfs_pkg::NPAGE];
  logic [7:0] input_r;
  logic [7:0] input_nxt;
  logic [7:0] cml_r;
  logic [7:0] cml_nxt;
  logic [7:0] mfr_r;
  logic [7:0] mfr_nxt;

  logic [7:0]  sbyte [pfs_pkg::NPAGE];
  logic [7:0]  shigh [pfs_pkg::NPAGE];
  logic [7:0]  mfr_pg [pfs_pkg::NPAGE];
  logic [pfs_pkg::NPAGE-1:0] page_alert;

  logic                      pg;
  logic                      wr_here;
  logic [15:0]               rd_nxt;
  logic                      alert_nxt;
  pfs_pkg::pfs_clr_e         clr_st_r;
  pfs_pkg::pfs_clr_e         clr_st_nxt;
  logic [pfs_pkg::CLR_CNT_W-1:0] clr_cnt_r;
  logic [pfs_pkg::CLR_CNT_W-1:0] clr_cnt_nxt;
  logic                      clr_now;
  // Write strobes decoded once for all registers
  logic                      wr_vout;
  logic                      wr_iout;
  logic                      wr_temp;
  logic                      wr_input;
  logic                      wr_cml;
  logic                      wr_mfr;

  assign pg = page_sel;
  // Clear pulse is applied once, at the command; the busy window only
  // models processing latency so software can wait for it.
  assign clr_now = clear_all_cmd;

  // Per-page flags and summaries
  genvar gi;
  generate
    for (gi = 0; gi < pfs_pkg::NPAGE; gi++)
    begin : g_page
      // Page match for the paged write-one clears
      logic sel;
      assign sel = (pg == 1'(gi));

      always_comb
      begin
        vout_nxt[gi] = clr_now ? pfs_pkg::FLAGS_RESET : vout_r[gi];
        iout_nxt[gi] = clr_now ? pfs_pkg::FLAGS_RESET : iout_r[gi];
        temp_nxt[gi] = clr_now ? pfs_pkg::FLAGS_RESET : temp_r[gi];
        gpio_nxt[gi] = clr_now ? 1'b0 : gpio_r[gi];
        busy_nxt[gi] = clr_now ? 1'b0 : busy_r[gi];
        nota_nxt[gi] = clr_now ? 1'b0 : nota_r[gi];
        if (sel && wr_vout)
          vout_nxt[gi] = vout_nxt[gi] & ~wr_data;
        if (sel && wr_iout)
          iout_nxt[gi] = iout_nxt[gi] & ~wr_data;
        if (sel && wr_temp)
          temp_nxt[gi] = temp_nxt[gi] & ~wr_data;
        if (sel && wr_mfr && wr_data[pfs_pkg::MFR_GPIO_BIT])
          gpio_nxt[gi] = 1'b0;
        vout_nxt[gi] = (vout_nxt[gi] | page_evt[gi].vout)
                       & pfs_pkg::VOUT_MASK;
        iout_nxt[gi] = (iout_nxt[gi] | page_evt[gi].iout)
                       & pfs_pkg::IOUT_MASK;
        temp_nxt[gi] = (temp_nxt[gi] | page_evt[gi].temp)
                       & pfs_pkg::TEMP_MASK;
        gpio_nxt[gi] = gpio_nxt[gi] | page_evt[gi].gpio_low;
        busy_nxt[gi] = busy_nxt[gi] | shared_evt.busy;
        nota_nxt[gi] = nota_nxt[gi] | page_evt[gi].other
                       | shared_evt.other;
      end

      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          vout_r[gi] <= pfs_pkg::FLAGS_RESET;
          iout_r[gi] <= pfs_pkg::FLAGS_RESET;
          temp_r[gi] <= pfs_pkg::FLAGS_RESET;
          gpio_r[gi] <= 1'b0;
          busy_r[gi] <= 1'b0;
          nota_r[gi] <= 1'b0;
        end
        else
        begin
          vout_r[gi] <= vout_nxt[gi];
          iout_r[gi] <= iout_nxt[gi];
          temp_r[gi] <= temp_nxt[gi];
          gpio_r[gi] <= gpio_nxt[gi];
          busy_r[gi] <= busy_nxt[gi];
          nota_r[gi] <= nota_nxt[gi];
        end
      end

      always_comb
      begin
        // shared maker bits plus page gpio bit
        mfr_pg[gi] = (mfr_r & pfs_pkg::MFR_SHARED)
                     | {7'h00, gpio_r[gi]};
        sbyte[gi][pfs_pkg::SB_BUSY] = busy_r[gi];
        sbyte[gi][pfs_pkg::SB_OFF]  = chan_off[gi];
        sbyte[gi][pfs_pkg::SB_OV]   =
          vout_r[gi][pfs_pkg::OUTPUT_OVERVOLTAGE_SUMMARY_FAULT_BIT];
        sbyte[gi][pfs_pkg::SB_OC]   =
          iout_r[gi][pfs_pkg::OUTPUT_OVERCURRENT_SUMMARY_FAULT_BIT];
        sbyte[gi][pfs_pkg::SB_UV]   = 1'b0;
        sbyte[gi][pfs_pkg::SB_TEMP] = |temp_r[gi];
        sbyte[gi][pfs_pkg::SB_CML]  = |cml_r;
        sbyte[gi][pfs_pkg::SB_NOTA] = nota_r[gi];
        shigh[gi] = 8'h00;
        shigh[gi][pfs_pkg::SW_VOUT] = |vout_r[gi];
        shigh[gi][pfs_pkg::SW_IOUT] = |iout_r[gi];
        shigh[gi][pfs_pkg::SW_IN]   = |input_r;
        shigh[gi][pfs_pkg::SW_MFR]  = |mfr_pg[gi];
        shigh[gi][pfs_pkg::SW_PGN]  = power_not_good[gi];
      end

      assign page_alert[gi] = (|vout_r[gi]) | (|iout_r[gi])
        | (|temp_r[gi]) | (|mfr_pg[gi]) | (|cml_r)
        | (|(input_r & pfs_pkg::INPUT_ALRT))
        | busy_r[gi] | nota_r[gi];
    end
  endgenerate

  assign wr_here = wr_stb;

  // Write decode; codes naming no writable register do nothing
  always_comb
  begin
    wr_vout  = 1'b0;
    wr_iout  = 1'b0;
    wr_temp  = 1'b0;
    wr_input = 1'b0;
    wr_cml   = 1'b0;
    wr_mfr   = 1'b0;
    if (wr_here)
    begin
      case (reg_sel)
        pfs_pkg::CMD_VOUT_FLAGS:  wr_vout  = 1'b1;
        pfs_pkg::CMD_IOUT_FLAGS:  wr_iout  = 1'b1;
        pfs_pkg::CMD_TEMP_FLAGS:  wr_temp  = 1'b1;
        pfs_pkg::CMD_INPUT_FLAGS: wr_input = 1'b1;
        pfs_pkg::CMD_CML_FLAGS:   wr_cml   = 1'b1;
        pfs_pkg::CMD_MFR_FLAGS:   wr_mfr   = 1'b1;
        default:                  wr_vout  = 1'b0;
      endcase
    end
  end

  // Shared flags: input, comm/memory/logic and maker bytes exist once,
  // so a write-one clear reaches them from either page
  always_comb
  begin
    input_nxt = clr_now ? pfs_pkg::FLAGS_RESET : input_r;
    cml_nxt   = clr_now ? pfs_pkg::FLAGS_RESET : cml_r;
    mfr_nxt   = clr_now ? pfs_pkg::FLAGS_RESET : mfr_r;
    // only bit 7 clears by write-one
    if (wr_input)
      input_nxt = input_nxt & ~(wr_data & pfs_pkg::INPUT_W1C);
    if (wr_cml)
      cml_nxt = cml_nxt & ~wr_data;
    // log bit excluded from write-one clear
    if (wr_mfr)
      mfr_nxt = mfr_nxt & ~(wr_data & pfs_pkg::MFR_W1C);
    if (fault_log_erase_cmd)
      mfr_nxt[pfs_pkg::MFR_LOG_BIT] = 1'b0;
    input_nxt = (input_nxt | shared_evt.input_flags) & pfs_pkg::INPUT_MASK;
    cml_nxt = (cml_nxt | shared_evt.comm_memory_logic_summary) & pfs_pkg::CML_MASK;
    mfr_nxt = (mfr_nxt | shared_evt.mfr) & pfs_pkg::MFR_SHARED;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      input_r <= pfs_pkg::FLAGS_RESET;
      cml_r   <= pfs_pkg::FLAGS_RESET;
      mfr_r   <= pfs_pkg::FLAGS_RESET;
    end
    else
    begin
      input_r <= input_nxt;
      cml_r   <= cml_nxt;
      mfr_r   <= mfr_nxt;
    end
  end

  // Clear processing window
  always_comb
  begin
    clr_st_nxt  = clr_st_r;
    clr_cnt_nxt = clr_cnt_r;
    case (clr_st_r)
      pfs_pkg::CLR_IDLE:
      begin
        if (clear_all_cmd)
        begin
          clr_st_nxt  = pfs_pkg::CLR_BUSY;
          clr_cnt_nxt = pfs_pkg::CLR_CNT_W'(pfs_pkg::CLR_CYCLES - 1);
        end
      end
      pfs_pkg::CLR_BUSY:
      begin
        // A clear while busy wipes flags but leaves the window running
        if (clr_cnt_r == '0)
          clr_st_nxt = pfs_pkg::CLR_IDLE;
        else
          clr_cnt_nxt = clr_cnt_r - 1'b1;
      end
      default:
      begin
        clr_st_nxt  = pfs_pkg::CLR_IDLE;
        clr_cnt_nxt = '0;
      end
    endcase
  end

  // Read data and alert
  always_comb
  begin
    case (reg_sel)
      pfs_pkg::CMD_SUMMARY_BYTE: rd_nxt = {8'h00, sbyte[pg]};
      pfs_pkg::CMD_SUMMARY_WORD: rd_nxt = {shigh[pg], sbyte[pg]};
      pfs_pkg::CMD_VOUT_FLAGS:   rd_nxt = {8'h00, vout_r[pg]};
      pfs_pkg::CMD_IOUT_FLAGS:   rd_nxt = {8'h00, iout_r[pg]};
      pfs_pkg::CMD_INPUT_FLAGS:  rd_nxt = {8'h00, input_r};
      pfs_pkg::CMD_TEMP_FLAGS:   rd_nxt = {8'h00, temp_r[pg]};
      pfs_pkg::CMD_CML_FLAGS:    rd_nxt = {8'h00, cml_r};
      pfs_pkg::CMD_MFR_FLAGS:    rd_nxt = {8'h00, mfr_pg[pg]};
      default:                   rd_nxt = 16'h0000;
    endcase
    // clear releases alert until a fault re-sets
    alert_nxt = |page_alert && !clr_now;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      clr_st_r   <= pfs_pkg::CLR_IDLE;
      clr_cnt_r  <= '0;
      rd_data    <= 16'h0000;
      alert      <= 1'b0;
      clear_busy <= 1'b0;
    end
    else
    begin
      clr_st_r   <= clr_st_nxt;
      clr_cnt_r  <= clr_cnt_nxt;
      rd_data    <= rd_nxt;
      alert      <= alert_nxt;
      clear_busy <= (clr_st_nxt == pfs_pkg::CLR_BUSY);
    end
  end

endmodule : pfs_status_bank

// >>> test/pfs_status_bank_properties.sv
// Port checker for the fault status bank.
// Bound to pfs_status_bank below; it sees that module's ports only.
`timescale 1ns/1ps
module pfs_status_bank_properties (
  // Clock and access
  input wire logic                      core_clk,
  input wire logic                      rst,
  input wire logic                      page_sel,
  input wire logic [7:0]                reg_sel,
  input wire logic                      clear_all_cmd,
  input wire logic [15:0]               rd_data,
  input wire logic                      clear_busy,
  // Events, state and alert
  input wire pfs_pkg::pfs_page_evt_s    page_evt [pfs_pkg::NPAGE],
  input wire pfs_pkg::pfs_shared_evt_s  shared_evt,
  input wire logic [pfs_pkg::NPAGE-1:0] chan_off,
  input wire logic [pfs_pkg::NPAGE-1:0] power_not_good,
  input wire logic                      alert
);
  logic        quiet;
  logic [10:0] since_clr_r;
  logic [10:0] since_clr_nxt;
  assign quiet = !(|page_evt[0] || |page_evt[1] || |shared_evt);
  // Saturates so a long run never wraps back into the window
  always_comb
  begin
    since_clr_nxt = since_clr_r;
    // A clear inside a running window leaves that window running
    if (clear_all_cmd
        && (since_clr_r == 11'h000 || since_clr_r > 11'h4E2))
      since_clr_nxt = 11'h001;
    else if (since_clr_r != 11'h000 && since_clr_r != 11'h7D0)
      since_clr_nxt = since_clr_r + 11'h001;
  end
  always_ff @(posedge core_clk)
    since_clr_r <= rst ? 11'h000 : since_clr_nxt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_evt_alert: assert property (page_evt[0].vout[7] |-> ##2 alert)
    else $error("alert missing after voltage fault");
  a_clear_release: assert property
    (clear_all_cmd && quiet ##1 quiet |=> !alert)
    else $error("alert held after global clear");
  a_clear_window: assert property
    (since_clr_r != 11'h000 |-> clear_busy == (since_clr_r <= 11'h4E2))
    else $error("clear window length wrong");
  a_unmapped_read: assert property
    (!(reg_sel inside {[8'h78:8'h7E], 8'h80}) |=> rd_data == 16'h0000)
    else $error("unmapped code read nonzero");
  a_vout_reserved: assert property
    (reg_sel == 8'h7A |=> (rd_data & 16'hFF01) == 16'h0000)
    else $error("voltage byte reserved bit set");
  a_word_reserved: assert property
    (reg_sel == 8'h79 |=> (rd_data & 16'h0708) == 16'h0000)
    else $error("summary word reserved bit set");
  a_live_levels: assert property (reg_sel == 8'h79 && !page_sel |=>
    rd_data[11] == $past(power_not_good[0])
    && rd_data[6] == $past(chan_off[0]))
    else $error("off or power flag not live");
  a_input_mask: assert property
    (reg_sel == 8'h7C |=> (rd_data & 16'hFF55) == 16'h0000)
    else $error("input byte unsupported bit set");
endmodule : pfs_status_bank_properties
bind pfs_status_bank pfs_status_bank_properties chk_u (
  .core_clk(core_clk), .rst(rst), .page_sel(page_sel), .reg_sel(reg_sel),
  .clear_all_cmd(clear_all_cmd), .rd_data(rd_data), .clear_busy(clear_busy),
  .page_evt(page_evt), .shared_evt(shared_evt), .chan_off(chan_off),
  .power_not_good(power_not_good), .alert(alert));

// >>> test/pfs_host_model.sv
// Host model: register reads, write-one clears and commands.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ps
module pfs_host_model (
  // Clock
  input  wire logic        core_clk,
  // Access toward the bank
  output logic             page_sel,
  output logic [7:0]       reg_sel,
  output logic             wr_stb,
  output logic [7:0]       wr_data,
  output logic             clear_all_cmd,
  output logic             fault_log_erase_cmd,
  input  wire logic [15:0] rd_data
);
  initial
  begin
    page_sel = 1'b0;
    reg_sel = 8'h00;
    wr_stb = 1'b0;
    wr_data = 8'h00;
    clear_all_cmd = 1'b0;
    fault_log_erase_cmd = 1'b0;
  end
  task automatic rd(input logic p, input logic [7:0] c,
                    output logic [15:0] d);
    @(posedge core_clk);
    page_sel <= p;
    reg_sel <= c;
    repeat (2) @(posedge core_clk);
    #1 d = rd_data;
  endtask : rd
  task automatic w1c(input logic p, input logic [7:0] c, input logic [7:0] d);
    @(posedge core_clk);
    page_sel <= p;
    reg_sel <= c;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
    wr_data <= ~d;
  endtask : w1c
  task automatic cmd(input logic erase);
    @(posedge core_clk);
    fault_log_erase_cmd <= erase;
    clear_all_cmd <= !erase;
    @(posedge core_clk);
    fault_log_erase_cmd <= 1'b0;
    clear_all_cmd <= 1'b0;
  endtask : cmd
endmodule : pfs_host_model

// >>> test/test_pfs_status_bank.sv
// Self-checking bench for the fault status bank and its host model.
// Assumes the checker binds itself to the bank.
`timescale 1ns/1ps
module test_pfs_status_bank;
  logic                     core_clk, rst, page_sel, wr_stb, clr, erase;
  logic                     clear_busy, alert;
  logic [7:0]               reg_sel, wr_data;
  logic [15:0]              rd_data;
  logic [1:0]               chan_off, pgn;
  pfs_pkg::pfs_page_evt_s   page_evt [pfs_pkg::NPAGE];
  pfs_pkg::pfs_shared_evt_s shared_evt;
  int                       err_total, n_tests;
  pfs_status_bank dut_u (.core_clk(core_clk), .rst(rst), .page_sel(page_sel),
    .reg_sel(reg_sel), .wr_stb(wr_stb), .wr_data(wr_data),
    .clear_all_cmd(clr), .fault_log_erase_cmd(erase), .rd_data(rd_data),
    .clear_busy(clear_busy), .page_evt(page_evt), .shared_evt(shared_evt),
    .chan_off(chan_off), .power_not_good(pgn), .alert(alert));
  pfs_host_model host_u (.core_clk(core_clk), .page_sel(page_sel),
    .reg_sel(reg_sel), .wr_stb(wr_stb), .wr_data(wr_data),
    .clear_all_cmd(clr), .fault_log_erase_cmd(erase), .rd_data(rd_data));
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic rc(input logic p, input logic [7:0] c,
                    input logic [15:0] m, input logic [15:0] e);
    logic [15:0] got;
    host_u.rd(p, c, got);
    check(got & m, e);
  endtask : rc
  task automatic ca(input logic e);
    repeat (2) @(posedge core_clk);
    #1 check({15'h0000, alert}, {15'h0000, e});
  endtask : ca
  // One-cycle event pulse, then time for flags and alert to settle
  task automatic fire(input logic p, input pfs_pkg::pfs_page_evt_s pe,
                      input pfs_pkg::pfs_shared_evt_s se);
    @(posedge core_clk);
    page_evt[0] <= p ? '0 : pe;
    page_evt[1] <= p ? pe : '0;
    shared_evt <= se;
    @(posedge core_clk);
    page_evt[0] <= '0;
    page_evt[1] <= '0;
    shared_evt <= '0;
    repeat (2) @(posedge core_clk);
  endtask : fire
  task automatic t_reset;
    logic [7:0] codes [9] = '{8'h78, 8'h79, 8'h7A, 8'h7B, 8'h7C, 8'h7D,
                             8'h7E, 8'h80, 8'h7F};
    foreach (codes[i]) rc(1'b0, codes[i], 16'hFFFF, 16'h0000);
    ca(1'b0);
    @(posedge core_clk);
    chan_off <= 2'b01;
    pgn <= 2'b10;
    rc(1'b0, 8'h78, 16'hFFFF, 16'h0040);
    rc(1'b1, 8'h78, 16'hFFFF, 16'h0000);
    rc(1'b1, 8'h79, 16'hFF00, 16'h0800);
    chan_off <= 2'b00;
    pgn <= 2'b00;
    $display("t_reset done");
  endtask : t_reset
  task automatic t_vout;
    fire(1'b0, {8'h80, 18'h0}, 26'h0);
    rc(1'b0, 8'h78, 16'hFFFF, 16'h0020);
    rc(1'b0, 8'h79, 16'hFFFF, 16'h8020);
    ca(1'b1);
    fire(1'b0, {8'h7E, 18'h0}, 26'h0);
    rc(1'b0, 8'h7A, 16'hFFFF, 16'h00FE);
    rc(1'b1, 8'h7A, 16'hFFFF, 16'h0000);
    host_u.w1c(1'b0, 8'h7A, 8'h82);
    rc(1'b0, 8'h7A, 16'hFFFF, 16'h007C);
    host_u.w1c(1'b0, 8'h7A, 8'hFF);
    rc(1'b0, 8'h7A, 16'hFFFF, 16'h0000);
    $display("t_vout done");
  endtask : t_vout
  task automatic t_input;
    fire(1'b0, 26'h0, {8'hFF, 18'h0});
    rc(1'b0, 8'h7C, 16'hFFFF, 16'h00AA);
    host_u.w1c(1'b0, 8'h7C, 8'hFF);
    rc(1'b0, 8'h7C, 16'hFFFF, 16'h002A);
    ca(1'b0);
    host_u.cmd(1'b0);
    rc(1'b0, 8'h7C, 16'hFFFF, 16'h0000);
    $display("t_input done");
  endtask : t_input
  task automatic t_mfr;
    fire(1'b1, 26'h2, {16'h0, 8'hFF, 2'b00});
    rc(1'b0, 8'h80, 16'hFFFF, 16'h00FC);
    rc(1'b1, 8'h80, 16'hFFFF, 16'h00FD);
    rc(1'b1, 8'h79, 16'hFF00, 16'h1000);
    ca(1'b1);
    host_u.w1c(1'b0, 8'h80, 8'hFF);
    rc(1'b0, 8'h80, 16'hFFFF, 16'h0008);
    rc(1'b1, 8'h80, 16'hFFFF, 16'h0009);
    host_u.cmd(1'b1);
    rc(1'b0, 8'h80, 16'hFFFF, 16'h0000);
    host_u.w1c(1'b1, 8'h80, 8'h01);
    rc(1'b1, 8'h80, 16'hFFFF, 16'h0000);
    $display("t_mfr done");
  endtask : t_mfr
  task automatic t_clear;
    int i;
    time t0;
    fire(1'b0, {16'h0020, 8'h40, 2'b00}, {16'h0080, 8'h00, 2'b11});
    rc(1'b0, 8'h78, 16'hFFFF, 16'h0087);
    fire(1'b0, {16'h00FF, 8'hFF, 2'b00}, {16'h00FF, 8'h00, 2'b00});
    rc(1'b0, 8'h7B, 16'hFFFF, 16'h00A0);
    rc(1'b0, 8'h7D, 16'hFFFF, 16'h00D0);
    rc(1'b0, 8'h7E, 16'hFFFF, 16'h00FB);
    rc(1'b0, 8'h78, 16'h0010, 16'h0010);
    host_u.w1c(1'b0, 8'h7B, 8'h80);
    rc(1'b0, 8'h7B, 16'hFFFF, 16'h0020);
    host_u.w1c(1'b0, 8'h7D, 8'h10);
    rc(1'b0, 8'h7D, 16'hFFFF, 16'h00C0);
    host_u.w1c(1'b0, 8'h7E, 8'h01);
    rc(1'b0, 8'h7E, 16'hFFFF, 16'h00FA);
    // Let the earlier window run out so this clear is timed alone
    i = 0;
    while (clear_busy !== 1'b0 && i < 2000)
    begin
      @(posedge core_clk);
      i++;
    end
    host_u.cmd(1'b0);
    t0 = $time;
    #1 check({15'h0000, clear_busy}, 16'h0001);
    rc(1'b0, 8'h78, 16'hFFFF, 16'h0000);
    rc(1'b0, 8'h7E, 16'hFFFF, 16'h0000);
    ca(1'b0);
    i = 0;
    while (clear_busy !== 1'b0 && i < 2000)
    begin
      @(posedge core_clk);
      #1 i++;
    end
    check({15'h0000, clear_busy}, 16'h0000);
    // Window length in whole cycles, counted from the clear's edge
    t0 = ($time - t0) / pfs_pkg::CLK_PERIOD_NS;
    check(16'(t0), 16'(pfs_pkg::CLR_CYCLES));
    $display("t_clear done");
  endtask : t_clear
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  initial
  begin
    err_total = 0;
    n_tests = 0;
    rst = 1'b1;
    chan_off = 2'b00;
    pgn = 2'b00;
    page_evt[0] = '0;
    page_evt[1] = '0;
    shared_evt = '0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_vout();
    t_input();
    t_mfr();
    t_clear();
    report_and_stop();
  end
  // Whole sequence needs about 2600 cycles, two clear windows included
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    report_and_stop();
  end
endmodule : test_pfs_status_bank
